// [inc/acsr_regs.svh]
// timing counts, pin positions and reset values for the conversion readout block
// Notes on behaviour
// - frame low, active low, frames every transfer
// - parallel: frame and strobe low drive bus
// - serial: frame fall starts, presents MSB
// - busy rises after both sample starts rise
// - busy fall latches results, readable after delay
// - sample starts ignored while busy high
// - marker floats while frame high
// - parallel/byte: marker high first strobe, low next
// - serial: marker high at frame, low 14th fall
// - select low: parallel pins driven on strobe
// - parallel pin n carries result bit n
// - byte: two strobes, bit 7 is MSB
// - serial: pin 7 output A, pin 8 B
// - parallel bits 15, 14 sign extend bit 13
// - byte order: high byte first when set
// - select low parallel, high serial or byte
// - serial clock rise shifts next bit out
`ifndef ACSR_REGS_SVH
`define ACSR_REGS_SVH
`define ACSR_CLK_MHZ 100
`define ACSR_CONV_TIME_NS 4000
`define ACSR_CONV_CYCLES ((`ACSR_CONV_TIME_NS * `ACSR_CLK_MHZ + 999) / 1000)
`define ACSR_LATCH_TO_READ_NS 25
`define ACSR_LATCH_TO_READ_CYCLES ((`ACSR_LATCH_TO_READ_NS * `ACSR_CLK_MHZ + 999) / 1000)
`define ACSR_SERIAL_MARKER_FALLS 14
`define ACSR_PIN_SEROUT_A 7
`define ACSR_PIN_SEROUT_B 8
`define ACSR_PIN_BYTE_SEL 15
`define ACSR_PIN_HIGH_FIRST 14
`define ACSR_RESULT_RESET 14'h0000
`endif

// [inc/acsr_pkg.sv]
// types of the conversion readout block
package acsr_pkg;
	typedef enum logic [1:0] {
		ACSR_IDLE = 2'b00,
		ACSR_CONVERT = 2'b01,
		ACSR_SETTLE = 2'b10
	} acsr_state_type;
	typedef enum logic [1:0] {
		ACSR_PAR = 2'b00,
		ACSR_SER = 2'b01,
		ACSR_BYTE = 2'b10
	} acsr_mode_type;
endpackage

// [design/acsr_readout.sv]
// conversion status and result readout: busy, result bank, parallel/byte/serial link
`timescale 1ns/1ps
`include "acsr_regs.svh"
module acsr_readout
	import acsr_pkg::*;
#(
	parameter int NCH = 8,
	parameter int RW = 14,
	parameter int CONV_CYCLES = `ACSR_CONV_CYCLES,
	parameter int L2R_CYCLES = `ACSR_LATCH_TO_READ_CYCLES
)
(
	// system side
	input wire logic clock,
	input wire logic srst,
	// conversion core
	input wire logic sample_start_a,
	input wire logic sample_start_b,
	input wire logic [NCH*RW-1:0] conv_codes,
	output logic busy,
	// host link
	input wire logic link_clock,
	input wire logic frame_n,
	input wire logic rd_sclk,
	input wire logic interface_select,
	// result bus pins
	input wire logic [15:0] result_bus_i,
	output logic [15:0] result_bus_o,
	output logic [15:0] result_bus_oe,
	// first channel marker pin
	output logic first_channel_marker,
	output logic first_channel_marker_oe
);
	localparam int HALF = NCH / 2;

	function automatic logic [15:0] sext16(input logic [RW-1:0] code);
		sext16 = {{(16 - RW){code[RW-1]}}, code};
	endfunction

	// ---------------- system clock domain ----------------
	logic sa_meta_q, sa_sync_q, sa_prev_q;
	logic sb_meta_q, sb_sync_q, sb_prev_q;
	logic armed_a_q, armed_b_q;
	logic busy_q;
	logic bank_tgl_q;
	logic [15:0] cnt_q;
	logic [RW-1:0] bank_q [0:NCH-1];
	acsr_state_type state_q;
	logic edge_a, edge_b, go;

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			sa_meta_q <= 1'b0;
			sa_sync_q <= 1'b0;
			sa_prev_q <= 1'b0;
			sb_meta_q <= 1'b0;
			sb_sync_q <= 1'b0;
			sb_prev_q <= 1'b0;
		end
		else
		begin
			sa_meta_q <= sample_start_a;
			sa_sync_q <= sa_meta_q;
			sa_prev_q <= sa_sync_q;
			sb_meta_q <= sample_start_b;
			sb_sync_q <= sb_meta_q;
			sb_prev_q <= sb_sync_q;
		end
	end

	assign edge_a = sa_sync_q & ~sa_prev_q;
	assign edge_b = sb_sync_q & ~sb_prev_q;
	assign go = (state_q == ACSR_IDLE) && (armed_a_q || edge_a) && (armed_b_q || edge_b);

	// edges only count while not busy
	always_ff @(posedge clock)
	begin
		if (srst || go)
		begin
			armed_a_q <= 1'b0;
			armed_b_q <= 1'b0;
		end
		else if (state_q != ACSR_CONVERT)
		begin
			armed_a_q <= armed_a_q | edge_a;
			armed_b_q <= armed_b_q | edge_b;
		end
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			state_q <= ACSR_IDLE;
			busy_q <= 1'b0;
			cnt_q <= 16'h0000;
			bank_tgl_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				ACSR_IDLE:
				begin
					if (go)
					begin
						state_q <= ACSR_CONVERT;
						busy_q <= 1'b1;
						cnt_q <= 16'(CONV_CYCLES - 1);
					end
				end
				ACSR_CONVERT:
				begin
					// busy holds until last channel done
					if (cnt_q == 16'h0000)
					begin
						state_q <= ACSR_SETTLE;
						busy_q <= 1'b0;
						cnt_q <= 16'(L2R_CYCLES - 1);
					end
					else
						cnt_q <= cnt_q - 16'h0001;
				end
				ACSR_SETTLE:
				begin
					// results handed over after the delay
					if (cnt_q == 16'h0000)
					begin
						state_q <= ACSR_IDLE;
						bank_tgl_q <= ~bank_tgl_q;
					end
					else
						cnt_q <= cnt_q - 16'h0001;
				end
				default:
				begin
					state_q <= ACSR_IDLE;
					busy_q <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		for (int i = 0; i < NCH; i++)
		begin
			if (srst)
				bank_q[i] <= `ACSR_RESULT_RESET;
			else if (state_q == ACSR_CONVERT && cnt_q == 16'h0000)
				bank_q[i] <= conv_codes[i*RW +: RW];
		end
	end

	assign busy = busy_q;

	// ---------------- link clock domain ----------------
	// bank words cross by toggle: bank_q is stable a whole conversion after it
	logic lrst_meta_q, lrst_q;
	logic tg_meta_q, tg_sync_q, tg_prev_q;
	logic fr_meta_q, fr_sync_q, fr_prev_q;
	logic rs_meta_q, rs_sync_q, rs_prev_q;
	logic is_meta_q, is_sync_q;
	logic [15:0] bi_meta_q, bi_sync_q;
	logic [RW-1:0] lbank_q [0:NCH-1];
	logic [2:0] chan_q;
	logic byte_hi_q;
	logic [3:0] bit_q;
	logic [4:0] fall_q;
	logic [RW-1:0] sh_a_q, sh_b_q;
	logic [15:0] bus_o_q, bus_oe_q;
	logic mark_q, mark_oe_q;
	acsr_mode_type mode;
	logic fr_fall, rs_rise, rs_fall, framed, strobe_lo, hi_first;
	logic [15:0] cur_word;
	logic [2:0] ser_word_q;

	always_ff @(posedge link_clock)
	begin
		lrst_meta_q <= srst;
		lrst_q <= lrst_meta_q;
	end

	always_ff @(posedge link_clock)
	begin
		if (lrst_q)
		begin
			tg_meta_q <= 1'b0;
			tg_sync_q <= 1'b0;
			tg_prev_q <= 1'b0;
			fr_meta_q <= 1'b1;
			fr_sync_q <= 1'b1;
			fr_prev_q <= 1'b1;
			rs_meta_q <= 1'b1;
			rs_sync_q <= 1'b1;
			rs_prev_q <= 1'b1;
			is_meta_q <= 1'b0;
			is_sync_q <= 1'b0;
			bi_meta_q <= 16'h0000;
			bi_sync_q <= 16'h0000;
		end
		else
		begin
			tg_meta_q <= bank_tgl_q;
			tg_sync_q <= tg_meta_q;
			tg_prev_q <= tg_sync_q;
			fr_meta_q <= frame_n;
			fr_sync_q <= fr_meta_q;
			fr_prev_q <= fr_sync_q;
			rs_meta_q <= rd_sclk;
			rs_sync_q <= rs_meta_q;
			rs_prev_q <= rs_sync_q;
			is_meta_q <= interface_select;
			is_sync_q <= is_meta_q;
			bi_meta_q <= result_bus_i;
			bi_sync_q <= bi_meta_q;
		end
	end

	assign fr_fall = fr_prev_q & ~fr_sync_q;
	assign framed = ~fr_sync_q;
	assign rs_rise = framed & rs_sync_q & ~rs_prev_q;
	assign rs_fall = framed & ~rs_sync_q & rs_prev_q;
	assign strobe_lo = framed & ~rs_sync_q;
	assign hi_first = bi_sync_q[`ACSR_PIN_HIGH_FIRST];
	assign cur_word = sext16(lbank_q[chan_q]);

	always_comb
	begin
		if (!is_sync_q)
			mode = ACSR_PAR;
		else if (bi_sync_q[`ACSR_PIN_BYTE_SEL])
			mode = ACSR_BYTE;
		else
			mode = ACSR_SER;
	end

	always_ff @(posedge link_clock)
	begin
		for (int i = 0; i < NCH; i++)
		begin
			if (lrst_q)
				lbank_q[i] <= `ACSR_RESULT_RESET;
			else if (tg_sync_q != tg_prev_q)
				lbank_q[i] <= bank_q[i];
		end
	end

	// channel walk, one word per strobe in parallel, one per two strobes in byte
	always_ff @(posedge link_clock)
	begin
		if (lrst_q || fr_fall)
		begin
			chan_q <= 3'h0;
			byte_hi_q <= 1'b0;
		end
		else if (rs_fall && mode != ACSR_SER)
		begin
			// two strobes per result in byte mode
			if (mode == ACSR_BYTE && !byte_hi_q)
				byte_hi_q <= 1'b1;
			else
			begin
				byte_hi_q <= 1'b0;
				chan_q <= chan_q + 3'h1;
			end
		end
	end

	always_ff @(posedge link_clock)
	begin
		if (lrst_q)
		begin
			bit_q <= 4'h0;
			sh_a_q <= `ACSR_RESULT_RESET;
			sh_b_q <= `ACSR_RESULT_RESET;
		end
		else if (fr_fall)
		begin
			bit_q <= 4'h0;
			sh_a_q <= lbank_q[0];
			sh_b_q <= lbank_q[HALF];
		end
		else if (rs_rise && mode == ACSR_SER)
		begin
			if (bit_q == 4'(RW - 1))
			begin
				// next channel pair, zeros once past the end
				bit_q <= 4'h0;
				sh_a_q <= (ser_word_q < 3'(HALF - 1)) ? lbank_q[ser_word_q + 3'h1] : '0;
				sh_b_q <= (ser_word_q < 3'(HALF - 1)) ? lbank_q[ser_word_q + 3'(HALF + 1)] : '0;
			end
			else
			begin
				bit_q <= bit_q + 4'h1;
				sh_a_q <= {sh_a_q[RW-2:0], 1'b0};
				sh_b_q <= {sh_b_q[RW-2:0], 1'b0};
			end
		end
	end

	// serial word index; chan_q only walks on strobes
	always_ff @(posedge link_clock)
	begin
		if (lrst_q || fr_fall)
			ser_word_q <= 3'h0;
		else if (rs_rise && mode == ACSR_SER && bit_q == 4'(RW - 1))
			ser_word_q <= ser_word_q + 3'h1;
	end

	// count clock falls since frame start
	always_ff @(posedge link_clock)
	begin
		if (lrst_q || fr_fall)
			fall_q <= 5'h00;
		else if (rs_fall && fall_q != 5'h1F)
			fall_q <= fall_q + 5'h01;
	end

	// marker level
	always_ff @(posedge link_clock)
	begin
		if (lrst_q)
			mark_q <= 1'b0;
		else if (fr_fall)
			// serial marker rises with channel one MSB
			mark_q <= (mode == ACSR_SER);
		else if (mode == ACSR_SER)
		begin
			if (rs_fall && fall_q == 5'(`ACSR_SERIAL_MARKER_FALLS - 1))
				mark_q <= 1'b0;
		end
		else if (rs_fall)
			// high for channel one strobe only
			mark_q <= (chan_q == 3'h0) && !byte_hi_q;
	end

	always_ff @(posedge link_clock)
	begin
		if (lrst_q)
			mark_oe_q <= 1'b0;
		else
			mark_oe_q <= framed;
	end

	// data pins
	always_ff @(posedge link_clock)
	begin
		if (lrst_q)
		begin
			bus_o_q <= 16'h0000;
			bus_oe_q <= 16'h0000;
		end
		else
		begin
			unique case (mode)
				ACSR_PAR:
				begin
					// pin n carries bit n, top bits sign extend
					if (rs_fall)
						bus_o_q <= sext16(lbank_q[chan_q]);
					// driven while frame and strobe low
					bus_oe_q <= {16{strobe_lo}};
				end
				ACSR_BYTE:
				begin
					if (rs_fall)
					begin
						if (byte_hi_q ^ hi_first)
							bus_o_q <= {8'h00, cur_word[15:8]};
						else
							bus_o_q <= {8'h00, cur_word[7:0]};
					end
					// low eight pins only; 15 and 14 stay inputs
					bus_oe_q <= {8'h00, {8{strobe_lo}}};
				end
				ACSR_SER:
				begin
					// output A on pin 7, B on pin 8
					bus_o_q <= 16'h0000;
					bus_o_q[`ACSR_PIN_SEROUT_A] <= sh_a_q[RW-1];
					bus_o_q[`ACSR_PIN_SEROUT_B] <= sh_b_q[RW-1];
					bus_oe_q <= 16'h0000;
					bus_oe_q[`ACSR_PIN_SEROUT_A] <= framed;
					bus_oe_q[`ACSR_PIN_SEROUT_B] <= framed;
				end
				default:
				begin
					bus_o_q <= 16'h0000;
					bus_oe_q <= 16'h0000;
				end
			endcase
		end
	end

	assign result_bus_o = bus_o_q;
	assign result_bus_oe = bus_oe_q;
	assign first_channel_marker = mark_q;
	assign first_channel_marker_oe = mark_oe_q;
endmodule

// [bench/acsr_readout_properties.sv]
// port-level checks of the conversion readout block
`timescale 1ns/1ps
module acsr_readout_checker
#(
	parameter int CONV_CYCLES = 10
)
(
	// system side
	input wire logic clock,
	input wire logic srst,
	input wire logic sample_start_a,
	input wire logic sample_start_b,
	input wire logic busy,
	// link side
	input wire logic link_clock,
	input wire logic frame_n,
	input wire logic rd_sclk,
	input wire logic interface_select,
	input wire logic [15:0] result_bus_o,
	input wire logic [15:0] result_bus_oe,
	input wire logic first_channel_marker_oe
);
	int busy_cnt_q;
	always_ff @(posedge clock)
	begin
		if (srst || !busy)
			busy_cnt_q <= 0;
		else
			busy_cnt_q <= busy_cnt_q + 1;
	end
	logic sa_prev_q, sb_prev_q, seen_a_q, seen_b_q;
	// start pins may pulse briefly, so remember their edges until busy
	always_ff @(posedge clock)
	begin
		sa_prev_q <= sample_start_a;
		sb_prev_q <= sample_start_b;
		if (srst || busy)
		begin
			seen_a_q <= 1'b0;
			seen_b_q <= 1'b0;
		end
		else
		begin
			seen_a_q <= seen_a_q | (sample_start_a & ~sa_prev_q);
			seen_b_q <= seen_b_q | (sample_start_b & ~sb_prev_q);
		end
	end
	property p_busy_cause;
		@(posedge clock) disable iff (srst) $rose(busy) |-> seen_a_q && seen_b_q;
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without starts");
	property p_busy_len;
		@(posedge clock) disable iff (srst)
		$fell(busy) |-> busy_cnt_q >= CONV_CYCLES - 1 && busy_cnt_q <= CONV_CYCLES;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length");
	property p_no_restart;
		@(posedge clock) disable iff (srst) $fell(busy) |-> !busy [*2];
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("busy restarted");
	property p_sign_ext;
		@(posedge link_clock) disable iff (srst)
		result_bus_oe == 16'hFFFF |-> result_bus_o[15:14] == {2{result_bus_o[13]}};
	endproperty
	a_sign_ext: assert property (p_sign_ext) else $error("sign bits");
	property p_oe_set;
		@(posedge link_clock) disable iff (srst)
		result_bus_oe inside {16'h0000, 16'hFFFF, 16'h00FF, 16'h0180};
	endproperty
	a_oe_set: assert property (p_oe_set) else $error("bus enable set");
	property p_oe_cause;
		@(posedge link_clock) disable iff (srst)
		$rose(|result_bus_oe) |-> !frame_n && (interface_select || !rd_sclk);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("bus driven early");
	property p_mk_on;
		@(posedge link_clock) disable iff (srst) $rose(first_channel_marker_oe) |-> !frame_n;
	endproperty
	a_mk_on: assert property (p_mk_on) else $error("marker driven early");
	property p_mk_off;
		@(posedge link_clock) disable iff (srst) $fell(first_channel_marker_oe) |-> frame_n;
	endproperty
	a_mk_off: assert property (p_mk_off) else $error("marker released early");
	c_conv: cover property (@(posedge clock) $fell(busy));
	c_par: cover property (@(posedge link_clock) result_bus_oe == 16'hFFFF);
	c_ser: cover property (@(posedge link_clock) result_bus_oe == 16'h0180);
endmodule
bind acsr_readout acsr_readout_checker #(.CONV_CYCLES(CONV_CYCLES)) chk_u (.clock, .srst,
	.sample_start_a, .sample_start_b, .busy, .link_clock, .frame_n, .rd_sclk,
	.interface_select, .result_bus_o, .result_bus_oe, .first_channel_marker_oe);

// [bench/acsr_host_model.sv]
// host side: frame, read strobe or serial clock, pin sampling
`timescale 1ns/1ps
module acsr_host_model
(
	// link timing
	input wire logic link_clock,
	// host drives
	output logic frame_n,
	output logic rd_sclk,
	// pins seen
	input wire logic [15:0] result_bus_o,
	input wire logic [15:0] result_bus_oe,
	input wire logic first_channel_marker,
	input wire logic first_channel_marker_oe
);
	initial
	begin
		frame_n = 1'b1;
		rd_sclk = 1'b1;
	end
	task automatic frame(input logic lvl, input logic idle);
	begin
		rd_sclk = idle;
		repeat (4) @(negedge link_clock);
		frame_n = lvl;
		repeat (6) @(negedge link_clock);
	end
	endtask
	// slow edge: the pins settle through the synchronisers
	task automatic edge_sample(input logic lvl, output logic [15:0] d, output logic m);
	begin
		rd_sclk = lvl;
		repeat (6) @(negedge link_clock);
		// released pins read back inverted so a missing drive shows
		d = result_bus_o ^ ~result_bus_oe;
		m = first_channel_marker ^ ~first_channel_marker_oe;
	end
	endtask
endmodule

// [bench/acsr_readout_tb.sv]
// self-checking bench of the conversion readout block
`timescale 1ns/1ps
module acsr_readout_tb;
	logic clock, srst, link_clock, sample_start_a, sample_start_b, interface_select, m;
	logic busy, frame_n, rd_sclk, first_channel_marker, first_channel_marker_oe;
	logic [111:0] conv_codes, codes;
	logic [15:0] host_drv, result_bus_i, result_bus_o, result_bus_oe, d;
	int mismatches, check_count;
	assign result_bus_i = (result_bus_o & result_bus_oe) | (host_drv & ~result_bus_oe);
	acsr_readout #(.CONV_CYCLES(10), .L2R_CYCLES(1)) dut_u (.clock(clock), .srst(srst),
		.sample_start_a(sample_start_a), .sample_start_b(sample_start_b),
		.conv_codes(conv_codes), .busy(busy), .link_clock(link_clock), .frame_n(frame_n),
		.rd_sclk(rd_sclk), .interface_select(interface_select), .result_bus_i(result_bus_i),
		.result_bus_o(result_bus_o), .result_bus_oe(result_bus_oe),
		.first_channel_marker(first_channel_marker),
		.first_channel_marker_oe(first_channel_marker_oe));
	acsr_host_model host_u (.link_clock(link_clock), .frame_n(frame_n), .rd_sclk(rd_sclk),
		.result_bus_o(result_bus_o), .result_bus_oe(result_bus_oe),
		.first_channel_marker(first_channel_marker),
		.first_channel_marker_oe(first_channel_marker_oe));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
	begin
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	end
	endtask
	task automatic final_report();
	begin
		if (mismatches == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	task automatic convert();
	begin
		conv_codes = codes;
		sample_start_a = 1'b1;
		repeat (10) @(negedge clock);
		chk("busy", 16'h0000, 16'(busy));
		sample_start_b = 1'b1;
		repeat (6) @(negedge clock);
		chk("busy", 16'h0001, 16'(busy));
		sample_start_a = 1'b0;
		sample_start_b = 1'b0;
		repeat (2) @(negedge clock);
		sample_start_a = 1'b1;
		sample_start_b = 1'b1;
		// look inside the span a remembered start would be busy
		repeat (12) @(negedge clock);
		chk("busy", 16'h0000, 16'(busy));
		sample_start_a = 1'b0;
		sample_start_b = 1'b0;
		conv_codes = ~codes;
	end
	endtask
	task automatic par_read();
		logic [13:0] c;
	begin
		interface_select = 1'b0;
		host_u.frame(1'b0, 1'b1);
		chk("marker_oe", 16'h0001, 16'(first_channel_marker_oe));
		for (int i = 0; i < 8; i++)
		begin
			c = codes[i*14 +: 14];
			host_u.edge_sample(1'b0, d, m);
			chk("par_data", {c[13], c[13], c}, d);
			chk("par_oe", 16'hFFFF, result_bus_oe);
			chk("marker", 16'(i == 0), 16'(m));
			host_u.edge_sample(1'b1, d, m);
			chk("par_oe", 16'h0000, result_bus_oe);
		end
		host_u.frame(1'b1, 1'b1);
		chk("marker_oe", 16'h0000, 16'(first_channel_marker_oe));
	end
	endtask
	task automatic byte_read();
		logic [15:0] x;
	begin
		x = {codes[13], codes[13], codes[13:0]};
		interface_select = 1'b1;
		for (int hb = 0; hb < 2; hb++)
		begin
			host_drv = {1'b1, 1'(hb), 14'h0000};
			host_u.frame(1'b0, 1'b1);
			host_u.edge_sample(1'b0, d, m);
			chk("byte_a", {8'h00, hb ? x[15:8] : x[7:0]}, d & 16'h00FF);
			chk("marker", 16'h0001, 16'(m));
			host_u.edge_sample(1'b1, d, m);
			host_u.edge_sample(1'b0, d, m);
			chk("byte_b", {8'h00, hb ? x[7:0] : x[15:8]}, d & 16'h00FF);
			chk("marker", 16'h0000, 16'(m));
			chk("byte_oe", 16'h00FF, result_bus_oe);
			host_u.edge_sample(1'b1, d, m);
			host_u.frame(1'b1, 1'b1);
		end
	end
	endtask
	task automatic ser_read();
		logic [13:0] a, b;
	begin
		host_drv = 16'h0000;
		host_u.frame(1'b0, 1'b0);
		chk("ser_marker", 16'h0001, 16'(first_channel_marker));
		chk("ser_oe", 16'h0180, result_bus_oe);
		a[13] = result_bus_o[7];
		b[13] = result_bus_o[8];
		for (int k = 12; k >= 0; k--)
		begin
			host_u.edge_sample(1'b1, d, m);
			a[k] = d[7];
			b[k] = d[8];
			host_u.edge_sample(1'b0, d, m);
		end
		chk("ser_marker", 16'h0001, 16'(m));
		chk("ser_a", 16'(codes[13:0]), 16'(a));
		chk("ser_b", 16'(codes[69:56]), 16'(b));
		host_u.edge_sample(1'b1, d, m);
		chk("ser_next", 16'(codes[27]), 16'(d[7]));
		host_u.edge_sample(1'b0, d, m);
		chk("ser_marker", 16'h0000, 16'(m));
		host_u.frame(1'b1, 1'b0);
	end
	endtask
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial
	begin
		link_clock = 1'b0;
		#3;
		forever #24 link_clock = ~link_clock;
	end
	initial
	begin
		srst = 1'b1;
		{sample_start_a, sample_start_b, interface_select} = 3'h0;
		host_drv = 16'h0000;
		conv_codes = '0;
		mismatches = 0;
		check_count = 0;
		for (int i = 0; i < 8; i++)
			codes[i*14 +: 14] = 14'h1A51 ^ 14'(i * 14'h0713);
		repeat (20) @(negedge clock);
		srst = 1'b0;
		repeat (10) @(negedge clock);
		convert();
		par_read();
		byte_read();
		ser_read();
		final_report();
	end
	// run needs about 19 us; allow more than double
	initial
	begin
		#60000;
		mismatches++;
		final_report();
	end
endmodule
